// *** design/ramini_defines.svh ***
// constants for the jtag ram initialisation loader
// assumes inclusion by bare name from every design file that needs a figure
`ifndef RAMINI_DEFINES_SVH
`define RAMINI_DEFINES_SVH

// ******************************************
// default geometry
// ******************************************
`define RAMINI_DATA_WIDTH 4
`define RAMINI_ADDR_WIDTH 2
`define RAMINI_BLOCKS 4
`define RAMINI_INSTR_WIDTH 8
`define RAMINI_COUNT_WIDTH 16

// ******************************************
// default user opcodes
// ******************************************
`define RAMINI_OPC_SWEEP 8'h22
`define RAMINI_OPC_ADDR_LOAD 8'h24
`define RAMINI_OPC_BROADCAST 8'h25
`define RAMINI_OPC_BLOCK_BASE 8'h30

// ******************************************
// reset values and synchroniser depth
// ******************************************
`define RAMINI_ADDR_RST 'h0
`define RAMINI_RING_RST 'h1
`define RAMINI_SYNC_STAGES 3

`endif

// *** design/ramini_pkg.sv ***
// types shared by the jtag ram initialisation loader
// assumes nothing beyond a systemverilog compiler
package ramini_pkg;
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_SWEEP,
		MODE_ADDR_LOAD,
		MODE_BROADCAST,
		MODE_BLOCK
	} ramini_mode_e;
endpackage : ramini_pkg

// *** design/ramini_shift_if.sv ***
// carrier between the loader core and one serial-in parallel-out register
// assumes both ends run on the same clk
`timescale 1ns/1ns
interface ramini_shift_if #(parameter int WIDTH = 4);
	logic shiftEn;
	logic serialIn;
	logic [WIDTH-1:0] q;
	modport owner (output shiftEn, output serialIn, input q);
	modport shifter (input shiftEn, input serialIn, output q);
endinterface : ramini_shift_if

// *** design/ramini_sync.sv ***
// three-stage synchroniser with agreement filter, any width
// assumes inputs are slow levels from outside the clk domain
`timescale 1ns/1ns
module ramini_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] asyncIn,
	input wire logic [WIDTH-1:0] resetLevel,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);
	wire [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level);

	// stage1 feeds only stage2; the filter looks at stages two and three
	always_ff @(posedge clk) begin
		stage1 <= asyncIn;
		stage2 <= stage1;
		stage3 <= stage2;
	end

	// resetLevel is a tie-off constant at the instance
	always_ff @(posedge clk) begin
		if (srst) begin
			level <= resetLevel;
		end else begin
			level <= next_level;
		end
	end
endmodule : ramini_sync

// *** design/ramini_shift_reg.sv ***
// serial-in parallel-out register, lsb arrives first
// assumes shiftEn is already a one-cycle qualified pulse on clk
`timescale 1ns/1ns
module ramini_shift_reg #(
	parameter int WIDTH = 4
) (
	input wire logic clk,
	input wire logic srst,
	ramini_shift_if.shifter port
);
	logic [WIDTH-1:0] q;
	wire [WIDTH-1:0] next_q = {port.serialIn, q[WIDTH-1:1]};

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
		end else if (port.shiftEn) begin
			q <= next_q;
		end
	end

	assign port.q = q;
endmodule : ramini_shift_reg

// *** design/ramini_loader.sv ***
// jtag ram initialisation loader: tap user port in, ram write port out
// assumes all tap user signals arrive asynchronously to clk and are slow
// against it; ram blocks sit outside and take writeClock as their clock
`timescale 1ns/1ns
`include "ramini_defines.svh"
module ramini_loader #(
	parameter int DATA_WIDTH = `RAMINI_DATA_WIDTH,
	parameter int ADDR_WIDTH = `RAMINI_ADDR_WIDTH,
	parameter int BLOCKS = `RAMINI_BLOCKS,
	parameter int INSTR_WIDTH = `RAMINI_INSTR_WIDTH,
	parameter int COUNT_WIDTH = `RAMINI_COUNT_WIDTH,
	parameter logic [INSTR_WIDTH-1:0] OPC_SWEEP = `RAMINI_OPC_SWEEP,
	parameter logic [INSTR_WIDTH-1:0] OPC_ADDR_LOAD = `RAMINI_OPC_ADDR_LOAD,
	parameter logic [INSTR_WIDTH-1:0] OPC_BROADCAST = `RAMINI_OPC_BROADCAST,
	parameter logic [INSTR_WIDTH-1:0] OPC_BLOCK_BASE = `RAMINI_OPC_BLOCK_BASE,
	parameter bit FALLING_EDGE_RAM = 1'b0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [INSTR_WIDTH-1:0] user_instruction_value,
	input wire logic user_serial_data_in,
	input wire logic user_dr_clock,
	input wire logic user_dr_shift_strobe,
	input wire logic user_dr_update_strobe,
	input wire logic userResetN,
	output logic [DATA_WIDTH-1:0] writeData,
	output logic [ADDR_WIDTH-1:0] writeAddr,
	output logic [BLOCKS-1:0] chipSelect,
	output logic [BLOCKS-1:0] writeEnable,
	output logic writeClock,
	output logic modeActive,
	output logic sweepDone,
	output logic [COUNT_WIDTH-1:0] wordCount
);

	// ******************************************
	// input synchronisation
	// ******************************************
	localparam int SYNC_W = INSTR_WIDTH + 5;

	logic [SYNC_W-1:0] syncLevel;
	logic [INSTR_WIDTH-1:0] instr;
	logic serialBit;
	logic drClockLevel;
	logic shiftLevel;
	logic updateLevel;
	logic userResetLevelN;

	// one instance keeps every tap input on the same four-flop latency,
	// so serial data and its clock stay aligned after the crossing
	ramini_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clk(clk),
		.srst(srst),
		.asyncIn({user_instruction_value, user_serial_data_in, user_dr_clock,
			user_dr_shift_strobe, user_dr_update_strobe, userResetN}),
		.resetLevel({{(INSTR_WIDTH + 4){1'b0}}, 1'b1}),
		.level(syncLevel)
	);

	assign instr = syncLevel[SYNC_W-1:5];
	assign serialBit = syncLevel[4];
	assign drClockLevel = syncLevel[3];
	assign shiftLevel = syncLevel[2];
	assign updateLevel = syncLevel[1];
	assign userResetLevelN = syncLevel[0];

	// ******************************************
	// edge detection
	// ******************************************
	logic drClockPrev;
	logic updatePrev;
	wire drClockRise = drClockLevel & ~drClockPrev;
	wire updateRise = updateLevel & ~updatePrev;
	wire counterReset = srst | ~userResetLevelN;

	always_ff @(posedge clk) begin
		if (srst) begin
			drClockPrev <= 1'b0;
			updatePrev <= 1'b0;
		end else begin
			drClockPrev <= drClockLevel;
			updatePrev <= updateLevel;
		end
	end

	// ******************************************
	// instruction decode
	// ******************************************
	wire sweepHit = (instr == OPC_SWEEP);
	wire addrLoadHit = (instr == OPC_ADDR_LOAD);
	wire broadcastHit = (instr == OPC_BROADCAST);
	wire [INSTR_WIDTH-1:0] blockOffset = instr - OPC_BLOCK_BASE;
	wire blockHit = (instr >= OPC_BLOCK_BASE) && (blockOffset < INSTR_WIDTH'(BLOCKS));

	ramini_pkg::ramini_mode_e mode;

	always_comb begin
		if (sweepHit) begin
			mode = ramini_pkg::MODE_SWEEP;
		end else if (addrLoadHit) begin
			mode = ramini_pkg::MODE_ADDR_LOAD;
		end else if (broadcastHit) begin
			mode = ramini_pkg::MODE_BROADCAST;
		end else if (blockHit) begin
			mode = ramini_pkg::MODE_BLOCK;
		end else begin
			mode = ramini_pkg::MODE_IDLE;
		end
	end

	wire writeMode = (mode == ramini_pkg::MODE_SWEEP) || (mode == ramini_pkg::MODE_BROADCAST) ||
		(mode == ramini_pkg::MODE_BLOCK);

	// ******************************************
	// serial shift registers
	// ******************************************
	ramini_shift_if #(.WIDTH(DATA_WIDTH)) dataShift ();
	ramini_shift_if #(.WIDTH(ADDR_WIDTH)) addrShift ();

	// shift on sampled rising edges of the data-register clock, strobe high
	wire shiftTick = drClockRise & shiftLevel;

	// address load owns the shift path under its opcode, so data stays put
	assign dataShift.shiftEn = shiftTick & (mode != ramini_pkg::MODE_ADDR_LOAD);
	assign dataShift.serialIn = serialBit;
	assign addrShift.shiftEn = shiftTick & (mode == ramini_pkg::MODE_ADDR_LOAD);
	assign addrShift.serialIn = serialBit;

	// width of the data register is the ram data width
	ramini_shift_reg #(
		.WIDTH(DATA_WIDTH)
	) u_data_shift (
		.clk(clk),
		.srst(srst),
		.port(dataShift)
	);

	ramini_shift_reg #(
		.WIDTH(ADDR_WIDTH)
	) u_addr_shift (
		.clk(clk),
		.srst(srst),
		.port(addrShift)
	);

	// ******************************************
	// data pipeline
	// ******************************************
	wire writeTick = updateRise & writeMode;

	always_ff @(posedge clk) begin
		if (srst) begin
			writeData <= '0;
		end else if (writeTick) begin
			writeData <= dataShift.q;
		end
	end

	// ******************************************
	// address generator
	// ******************************************
	// useAsIs marks an address that has not been written yet (after reset or
	// after a tap address load); the next word goes there without a step
	logic useAsIs;
	logic [ADDR_WIDTH-1:0] next_writeAddr;
	logic next_useAsIs;
	logic ringStep;

	wire addrAtEnd = (writeAddr == {ADDR_WIDTH{1'b1}});
	wire addrLoadTick = updateRise & (mode == ramini_pkg::MODE_ADDR_LOAD);

	always_comb begin
		next_writeAddr = writeAddr;
		next_useAsIs = useAsIs;
		ringStep = 1'b0;
		if (addrLoadTick) begin
			next_writeAddr = addrShift.q;
			next_useAsIs = 1'b1;
		end else if (writeTick) begin
			next_useAsIs = 1'b0;
			if (!useAsIs) begin
				next_writeAddr = writeAddr + 1'b1;
				ringStep = addrAtEnd && (mode == ramini_pkg::MODE_SWEEP);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (counterReset) begin
			writeAddr <= ADDR_WIDTH'(`RAMINI_ADDR_RST);
			useAsIs <= 1'b1;
		end else begin
			writeAddr <= next_writeAddr;
			useAsIs <= next_useAsIs;
		end
	end

	// ******************************************
	// block select ring counter
	// ******************************************
	logic [BLOCKS-1:0] ring;
	wire [BLOCKS-1:0] ringRotated = {ring[BLOCKS-2:0], ring[BLOCKS-1]};
	wire ringWrap = ringStep & ring[BLOCKS-1];
	// selects take the stepped ring at once, so the first word of a new block
	// leaves with its own chip select and not the old block's
	wire [BLOCKS-1:0] next_ring = ringStep ? ringRotated : ring;

	// stepped only by the address generator, never by a free clock
	always_ff @(posedge clk) begin
		if (counterReset) begin
			ring <= BLOCKS'(`RAMINI_RING_RST);
		end else if (ringStep) begin
			ring <= ringRotated;
		end
	end

	// sticky: the last block finished its sweep
	always_ff @(posedge clk) begin
		if (counterReset) begin
			sweepDone <= 1'b0;
		end else if (ringWrap) begin
			sweepDone <= 1'b1;
		end
	end

	// ******************************************
	// select and enable generation
	// ******************************************
	logic [BLOCKS-1:0] selectVec;
	logic [BLOCKS-1:0] blockOneHot;

	always_comb begin
		blockOneHot = '0;
		for (int i = 0; i < BLOCKS; i++) begin
			blockOneHot[i] = (blockOffset == INSTR_WIDTH'(i));
		end
	end

	always_comb begin
		case (mode)
			ramini_pkg::MODE_SWEEP: begin
				selectVec = next_ring;
			end
			ramini_pkg::MODE_BROADCAST: begin
				selectVec = {BLOCKS{1'b1}};
			end
			ramini_pkg::MODE_BLOCK: begin
				selectVec = blockOneHot;
			end
			ramini_pkg::MODE_ADDR_LOAD: begin
				selectVec = '0;
			end
			default: begin
				selectVec = '0;
			end
		endcase
	end

	// selects and enables move with the data so the ram sees them settled
	// before its write edge
	always_ff @(posedge clk) begin
		if (srst) begin
			chipSelect <= '0;
			writeEnable <= '0;
			modeActive <= 1'b0;
		end else begin
			chipSelect <= selectVec;
			writeEnable <= writeMode ? selectVec : '0;
			modeActive <= writeMode;
		end
	end

	// ******************************************
	// write clock
	// ******************************************
	// the clock follows the same sampled strobe that loads data and address,
	// so data is stable for the whole strobe high time before the write edge
	wire next_writeClock = FALLING_EDGE_RAM ? updateLevel : ~updateLevel;

	always_ff @(posedge clk) begin
		if (srst) begin
			writeClock <= FALLING_EDGE_RAM ? 1'b0 : 1'b1;
		end else begin
			writeClock <= next_writeClock;
		end
	end

	// ******************************************
	// word counter
	// ******************************************
	// counts words written since the last reset; wraps silently
	always_ff @(posedge clk) begin
		if (counterReset) begin
			wordCount <= '0;
		end else if (writeTick) begin
			wordCount <= wordCount + 1'b1;
		end
	end

endmodule : ramini_loader

// *** testbench/ramini_chk.sv ***
// concurrent checks on the ram initialisation loader ports
// assumes binding to ramini_loader; tap strobes last well over eight clk
`timescale 1ns/1ns
module ramini_chk #(
	parameter int DATA_WIDTH = 4,
	parameter int ADDR_WIDTH = 2,
	parameter int BLOCKS = 4,
	parameter int INSTR_WIDTH = 8,
	parameter int COUNT_WIDTH = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [INSTR_WIDTH-1:0] user_instruction_value,
	input wire logic user_serial_data_in,
	input wire logic user_dr_clock,
	input wire logic user_dr_shift_strobe,
	input wire logic user_dr_update_strobe,
	input wire logic userResetN,
	input wire logic [DATA_WIDTH-1:0] writeData,
	input wire logic [ADDR_WIDTH-1:0] writeAddr,
	input wire logic [BLOCKS-1:0] chipSelect,
	input wire logic [BLOCKS-1:0] writeEnable,
	input wire logic writeClock,
	input wire logic modeActive,
	input wire logic sweepDone,
	input wire logic [COUNT_WIDTH-1:0] wordCount
);
	// ******************************************
	// port relations
	// ******************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// eight idle cycles are margin only; mode, enable and select registers load on the same edge
	idle_off_a: assert property ((!modeActive) [*8] |-> writeEnable == '0 && chipSelect == '0)
		else $error("enable or select without write opcode");
	one_target_a: assert property (writeEnable != '0 |-> $onehot(writeEnable) || &writeEnable)
		else $error("write enable neither one block nor all");
	select_with_write_a: assert property (writeEnable != '0 |-> chipSelect != '0)
		else $error("write enable without chip select");
	data_align_a: assert property (($changed(writeData) || $changed(writeAddr)) && wordCount != '0
		|-> $fell(writeClock)) else $error("data or address moved off the write clock fall");
	count_step_a: assert property ($changed(wordCount) && wordCount != '0
		|-> $fell(writeClock) && wordCount == $past(wordCount) + 1'b1) else $error("word count step wrong");
	no_mode_hold_a: assert property ($fell(writeClock) && !modeActive |-> $stable(wordCount))
		else $error("word counted without write opcode");
	done_clear_a: assert property ($fell(sweepDone) |-> wordCount == '0)
		else $error("sweep done cleared without counter reset");
	strobe_width_a: assert property ($fell(writeClock) |-> !writeClock [*8])
		else $error("write clock low phase too short");
	cover property ($rose(sweepDone));
	cover property (&writeEnable);
	cover property ($fell(writeClock) && writeAddr == '0 && wordCount > 1);
endmodule : ramini_chk

bind ramini_loader ramini_chk #(.DATA_WIDTH(DATA_WIDTH), .ADDR_WIDTH(ADDR_WIDTH), .BLOCKS(BLOCKS),
	.INSTR_WIDTH(INSTR_WIDTH), .COUNT_WIDTH(COUNT_WIDTH)) i_ramini_chk (.clk(clk), .srst(srst),
	.user_instruction_value(user_instruction_value), .user_serial_data_in(user_serial_data_in),
	.user_dr_clock(user_dr_clock), .user_dr_shift_strobe(user_dr_shift_strobe),
	.user_dr_update_strobe(user_dr_update_strobe), .userResetN(userResetN), .writeData(writeData),
	.writeAddr(writeAddr), .chipSelect(chipSelect), .writeEnable(writeEnable), .writeClock(writeClock),
	.modeActive(modeActive), .sweepDone(sweepDone), .wordCount(wordCount));

// *** testbench/ramini_tap_model.sv ***
// tap user-port model: instruction, serial data, data-register clock, strobes
// assumes one caller sequencing one operation at a time
`timescale 1ns/1ns
module ramini_tap_model (
	output logic [7:0] user_instruction_value,
	output logic user_serial_data_in,
	output logic user_dr_clock,
	output logic user_dr_shift_strobe,
	output logic user_dr_update_strobe,
	output logic userResetN
);
	// ******************************************
	// tap behaviour
	// ******************************************
	initial begin
		user_instruction_value = 8'h00;
		user_serial_data_in = 1'b0;
		user_dr_clock = 1'b0;
		user_dr_shift_strobe = 1'b0;
		user_dr_update_strobe = 1'b0;
		userResetN = 1'b1;
	end
	// 125 ns period; the clock stands still between frames
	// non-blocking: the 125 ns grid lands on clk rising edges every other tick
	task automatic tick();
		#62 user_dr_clock <= 1'b1;
		#63 user_dr_clock <= 1'b0;
	endtask : tick
	task automatic shift(input logic [7:0] v, input int n);
		user_dr_shift_strobe <= 1'b1;
		for (int i = 0; i < n; i++) begin
			user_serial_data_in <= v[i];
			tick();
		end
		user_dr_shift_strobe <= 1'b0;
		// released line flips so a late sample cannot match by luck
		user_serial_data_in <= ~user_serial_data_in;
		repeat (2) tick();
		user_dr_update_strobe <= 1'b1;
	endtask : shift
	task automatic endUpdate();
		tick();
		user_dr_update_strobe <= 1'b0;
	endtask : endUpdate
	task automatic setIr(input logic [7:0] v);
		user_instruction_value = v;
		#100;
	endtask : setIr
	task automatic userReset();
		userResetN = 1'b0;
		#100 userResetN = 1'b1;
		#100;
	endtask : userReset
endmodule : ramini_tap_model

// *** testbench/testbench.sv ***
// self-checking bench for the ram initialisation loader
// assumes the tap model drives every tap-side input
`timescale 1ns/1ns
`define RAMINI_CHK(act, exp) begin compares++; if ((act) !== (exp)) begin errCount++; \
	$display("Error at %0t: got %h expected %h", $time, act, exp); end end
module testbench;
	logic clk, srst, serialIn, drClock, shiftStrobe, updateStrobe, userResetN;
	logic [7:0] instr;
	logic [3:0] writeData, chipSelect, writeEnable;
	logic [1:0] writeAddr;
	logic writeClock, modeActive, sweepDone;
	logic [15:0] wordCount;
	int errCount, compares;
	// ******************************************
	// instances and clock
	// ******************************************
	ramini_tap_model i_ramini_tap_model (.user_instruction_value(instr), .user_serial_data_in(serialIn),
		.user_dr_clock(drClock), .user_dr_shift_strobe(shiftStrobe), .user_dr_update_strobe(updateStrobe),
		.userResetN(userResetN));
	ramini_loader i_ramini_loader (.clk(clk), .srst(srst), .user_instruction_value(instr),
		.user_serial_data_in(serialIn), .user_dr_clock(drClock), .user_dr_shift_strobe(shiftStrobe),
		.user_dr_update_strobe(updateStrobe), .userResetN(userResetN), .writeData(writeData),
		.writeAddr(writeAddr), .chipSelect(chipSelect), .writeEnable(writeEnable), .writeClock(writeClock),
		.modeActive(modeActive), .sweepDone(sweepDone), .wordCount(wordCount));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ******************************************
	// tasks
	// ******************************************
	task automatic wrapUp();
		$display("compares %0d errors %0d", compares, errCount);
		if (errCount == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrapUp
	task automatic waitClk(input logic lvl);
		for (int i = 0; i < 40 && writeClock !== lvl; i++) begin
			@(negedge clk);
		end
		if (writeClock !== lvl) begin
			errCount++;
			$display("Error at %0t: write clock %h expected %h", $time, writeClock, lvl);
			wrapUp();
		end
	endtask : waitClk
	// eight bits per word: the first nibble must be pushed out again
	task automatic word(input logic [7:0] v, input logic [1:0] a, input logic [3:0] en, input logic [15:0] cnt);
		i_ramini_tap_model.shift(v, 8);
		waitClk(1'b0);
		`RAMINI_CHK(writeData, v[7:4])
		`RAMINI_CHK(writeAddr, a)
		`RAMINI_CHK(writeEnable, en)
		`RAMINI_CHK(chipSelect, en)
		`RAMINI_CHK(wordCount, cnt)
		i_ramini_tap_model.endUpdate();
		waitClk(1'b1);
	endtask : word
	// ******************************************
	// sequence
	// ******************************************
	initial begin
		errCount = 0;
		compares = 0;
		srst = 1'b1;
		repeat (4) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		`RAMINI_CHK({writeData, writeAddr, chipSelect, writeEnable}, 14'h0)
		`RAMINI_CHK({writeClock, modeActive, sweepDone, wordCount}, 19'h40000)
		$display("test reset done");
		i_ramini_tap_model.setIr(8'h11);
		word(8'h0f, 2'h0, 4'h0, 16'h0);
		`RAMINI_CHK(modeActive, 1'b0)
		i_ramini_tap_model.shift(8'hf0, 8);
		waitClk(1'b0);
		`RAMINI_CHK(writeData, 4'h0)
		i_ramini_tap_model.endUpdate();
		waitClk(1'b1);
		$display("test unmatched done");
		i_ramini_tap_model.setIr(8'h22);
		`RAMINI_CHK(modeActive, 1'b1)
		for (int i = 0; i < 16; i++) begin
			word({i[3:0], ~i[3:0]}, i[1:0], 4'h1 << i[3:2], 16'(i + 1));
		end
		i_ramini_tap_model.shift(8'h00, 8);
		waitClk(1'b0);
		`RAMINI_CHK(writeAddr, 2'h0)
		i_ramini_tap_model.endUpdate();
		waitClk(1'b1);
		`RAMINI_CHK(sweepDone, 1'b1)
		$display("test sweep done");
		i_ramini_tap_model.userReset();
		`RAMINI_CHK({sweepDone, writeAddr, wordCount}, 19'h0)
		i_ramini_tap_model.setIr(8'h25);
		word(8'ha5, 2'h0, 4'hf, 16'h1);
		$display("test broadcast done");
		i_ramini_tap_model.setIr(8'h24);
		i_ramini_tap_model.shift(8'h02, 2);
		waitClk(1'b0);
		`RAMINI_CHK({writeEnable, wordCount}, 20'h00001)
		i_ramini_tap_model.endUpdate();
		waitClk(1'b1);
		for (int i = 0; i < 4; i++) begin
			i_ramini_tap_model.setIr(8'h30 + 8'(i));
			word(8'(i * 16 + 3), 2'(i + 2), 4'h1 << i, 16'(i + 2));
		end
		$display("test address load done");
		wrapUp();
	end
endmodule : testbench
